// ---- dv/iept_pulse_src.sv ----
`timescale 1ns/100ps
module iept_pulse_src (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // pulse control
  input  wire logic       enable,
  input  wire logic [7:0] halfPeriod,
  // driven lines
  output logic            channelInputPin,
  output logic            otherTimerOverflow,
  output logic            subClock
);
  logic [7:0] cnt;
  logic [2:0] ovfCnt;
  // pin stands low while disabled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 8'h0;
      ovfCnt <= 3'h0;
      channelInputPin <= 1'b0;
      otherTimerOverflow <= 1'b0;
      subClock <= 1'b0;
    end else begin
      subClock <= ~subClock;
      ovfCnt <= ovfCnt + 3'h1;
      otherTimerOverflow <= (ovfCnt == 3'h7);
      cnt <= (!enable || cnt == halfPeriod - 8'h1) ? 8'h0 : cnt + 8'h1;
      if (!enable)
        channelInputPin <= 1'b0;
      else if (cnt == halfPeriod - 8'h1)
        channelInputPin <= ~channelInputPin;
    end
  end
endmodule // iept_pulse_src

// ---- dv/iept_timer_chk.sv ----
`timescale 1ns/100ps
module iept_timer_chk
  import iept_pkg::*;
#(parameter int ADDR_W = 4) (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst,
  // write side
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  // read side
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // timer output
  input wire logic              irqRequest
);
  logic startSh;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence wTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // shadow of the start flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      startSh <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
             && s_axi_awaddr == IEPT_OFS_START)
      startSh <= s_axi_wdata[0];
  end
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("bresp not held");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("rdata not held");
  AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during response");
  AST_W_OK: assert property ((wTake ##0 (s_axi_awaddr == IEPT_OFS_START
    || s_axi_awaddr == IEPT_OFS_MODE || s_axi_awaddr == IEPT_OFS_TIMER)) |-> ##2 s_axi_bvalid
    && s_axi_bresp == IEPT_RESP_OK) else $error("mapped write response wrong");
  AST_W_ERR: assert property ((wTake ##0 s_axi_awaddr >= 4'hc) |-> ##2 s_axi_bvalid
    && s_axi_bresp == IEPT_RESP_ERR) else $error("unmapped write response wrong");
  AST_R_ERR: assert property ((rTake ##0 s_axi_araddr >= 4'hc) |=> s_axi_rvalid
    && s_axi_rresp == IEPT_RESP_ERR && s_axi_rdata == 32'h0) else $error("unmapped read wrong");
  AST_R_TMR: assert property ((rTake ##0 s_axi_araddr == IEPT_OFS_TIMER) |=>
    s_axi_rvalid && s_axi_rdata[31:16] == 16'h0) else $error("timer read too wide");
  AST_STOP_QUIET: assert property (!startSh && !$past(startSh, 3) |-> !irqRequest)
    else $error("request while stopped");
endmodule // iept_timer_chk

bind iept_timer iept_timer_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ---- dv/interval_event_pulse_timer_tb_top.sv ----
`timescale 1ns/100ps
module interval_event_pulse_timer_tb_top;
  import iept_pkg::*;
  localparam int          SRCDIV [4] = '{1, 8, 32, 64};
  localparam logic [31:0] EVMODE [4] = '{32'h01, 32'h05, 32'h09, 32'h11};
  localparam int          EVGAP  [4] = '{18, 18, 9, 24};
  logic        core_clk, rst, enable, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, irqRequest;
  logic        channelInputPin, otherTimerOverflow, subClock;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [7:0]  halfPeriod;
  int          mismatches, num_checks, n;

  iept_timer dut (.*);
  iept_pulse_src src (.*);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask

  task automatic ck(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    check(rd, exp);
  endtask

  task automatic wirq();
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!irqRequest);
  endtask

  // third request gives a clean reload-to-reload span
  task automatic gap(input int exp);
    repeat (3) wirq();
    check(32'(n), 32'(exp));
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end

  initial begin
    {rst, enable, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h10;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h0;
    {s_axi_wdata, halfPeriod, s_axi_wstrb} = {32'h0, 8'h03, 4'hf};
    {mismatches, num_checks} = 64'h0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    ck(IEPT_OFS_TIMER, 32'h0);
    ck(IEPT_OFS_MODE, 32'h0);
    ck(4'hc, 32'h0);
    check({30'h0, rs}, {30'h0, IEPT_RESP_ERR});
    wr(4'hc, 32'h1);
    check({30'h0, rs}, {30'h0, IEPT_RESP_ERR});
    enable <= 1'b1;
    wr(IEPT_OFS_TIMER, 32'h3);
    ck(IEPT_OFS_TIMER, 32'h3);
    wr(IEPT_OFS_START, 32'h1);
    gap(4);
    // one idle edge so the write lands between two underflows
    @(posedge core_clk);
    wr(IEPT_OFS_TIMER, 32'h100);
    wirq();
    check(32'(n < 6), 32'h1);
    gap(257);
    wr(IEPT_OFS_TIMER, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr(IEPT_OFS_MODE, {24'h0, s[1:0], 6'h0});
      gap(2 * SRCDIV[s]);
    end
    // stop lands just after a reload to one, long before the next tick
    wr(IEPT_OFS_START, 32'h0);
    ck(IEPT_OFS_TIMER, 32'h1);
    // wait past one subclock tick, a running counter would show zero
    repeat (70) @(posedge core_clk);
    ck(IEPT_OFS_TIMER, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(IEPT_OFS_MODE, EVMODE[i]);
      wr(IEPT_OFS_TIMER, 32'h2);
      wr(IEPT_OFS_START, 32'h1);
      gap(EVGAP[i]);
      wr(IEPT_OFS_START, 32'h0);
    end
    enable <= 1'b0;
    wr(IEPT_OFS_MODE, 32'h02);
    wr(IEPT_OFS_START, 32'h1);
    enable <= 1'b1;
    wirq();
    check(32'(n > 10), 32'h1);
    ck(IEPT_OFS_TIMER, 32'h5);
    wr(IEPT_OFS_TIMER, 32'h1234);
    ck(IEPT_OFS_TIMER, 32'h5);
    wr(IEPT_OFS_MODE, 32'h0a);
    repeat (2) wirq();
    ck(IEPT_OFS_TIMER, 32'h2);
    enable <= 1'b0;
    repeat (4) @(posedge core_clk);
    wr(IEPT_OFS_MODE, 32'h02);
    wirq();
    ck(IEPT_OFS_MODE, 32'h22);
    wr(IEPT_OFS_MODE, 32'h02);
    ck(IEPT_OFS_MODE, 32'h02);
    wr(IEPT_OFS_START, 32'h0);
    wr(IEPT_OFS_MODE, 32'h22);
    ck(IEPT_OFS_MODE, 32'h02);
    end_sim();
  end
endmodule // interval_event_pulse_timer_tb_top

// ---- rtl/iept_pkg.sv ----
package iept_pkg;
  // register byte offsets
  localparam logic [3:0] IEPT_OFS_START = 4'h0;
  localparam logic [3:0] IEPT_OFS_MODE  = 4'h4;
  localparam logic [3:0] IEPT_OFS_TIMER = 4'h8;
  // reset values and counter maximum
  localparam logic [15:0] IEPT_CNT_RST   = 16'h0000;
  localparam logic [15:0] IEPT_CNT_MAX   = 16'hffff;
  localparam logic [7:0]  IEPT_MODE_RST  = 8'h00;
  // prescaler terminal counts
  localparam logic [4:0]  IEPT_DIV8_END  = 5'h07;
  localparam logic [4:0]  IEPT_DIV32_END = 5'h1f;
  // operation mode field codes
  localparam logic [1:0]  IEPT_OP_TIMER  = 2'h0;
  localparam logic [1:0]  IEPT_OP_EVENT  = 2'h1;
  localparam logic [1:0]  IEPT_OP_MEAS   = 2'h2;
  // measurement select codes
  localparam logic [1:0]  IEPT_MS_FALL   = 2'h0;
  localparam logic [1:0]  IEPT_MS_RISE   = 2'h1;
  localparam logic [1:0]  IEPT_MS_WIDTH  = 2'h2;
  // event edge select codes (same field in event mode)
  localparam logic [1:0]  IEPT_EV_RISE   = 2'h0;
  localparam logic [1:0]  IEPT_EV_FALL   = 2'h1;
  localparam logic [1:0]  IEPT_EV_BOTH   = 2'h2;
  // count source codes
  localparam logic [1:0]  IEPT_SRC_F1    = 2'h0;
  localparam logic [1:0]  IEPT_SRC_DIV8  = 2'h1;
  localparam logic [1:0]  IEPT_SRC_DIV32 = 2'h2;
  localparam logic [1:0]  IEPT_SRC_SUB32 = 2'h3;
  // bus responses
  localparam logic [1:0]  IEPT_RESP_OK   = 2'h0;
  localparam logic [1:0]  IEPT_RESP_ERR  = 2'h2;

  // mode register layout, msb first
  typedef struct packed {
    logic [1:0] sourceSelect;
    logic       overflowFlag;
    logic       eventFromTimer;
    logic [1:0] measureSelect;
    logic [1:0] opMode;
  } iept_mode_s;

  // one register write delivered to the timer logic
  typedef struct packed {
    logic        start;
    logic        mode;
    logic        timer;
    logic [31:0] data;
    logic [3:0]  strb;
  } iept_wr_s;
endpackage

// ---- rtl/iept_timer.sv ----
// How it works
// - timer and event modes count down, reload on underflow, keep counting
// - set value n gives one underflow per n plus one ticks
// - counting happens only while the start flag is one
// - timer and event modes raise an interrupt request on each underflow
// - timer mode ignores the channel input pin entirely
// - timer and event modes read back the live counter
// - timer write while stopped loads reload register and counter
// - timer write while running loads only reload register
// - event mode counts pin edges (rise, fall, both) or other overflow
// - measurement counts up, captures on edge, restarts from zero
// - measurement raises an interrupt request at each effective edge except the first after start
// - first effective edge after start raises no interrupt request
// - measurement overflow raises request and sets overflow flag together
// - mode write while running clears the overflow flag
// - measurement read returns the reload register, the last result
// - measurement mode ignores timer register writes
// - measurement result meaningless before second edge after start
// - operation mode code 10 selects measurement mode
// - measure select: 00 fall-fall, 01 rise-rise, 10 width, 11 prohibited
// - overflow flag is read-only, software never sets it
// - source select: 00 undivided, 01 div8, 10 div32, 11 subclock div32
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module iept_timer #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // count inputs
  input  wire logic              channelInputPin,
  input  wire logic              otherTimerOverflow,
  input  wire logic              subClock,
  // interrupt request
  output logic                   irqRequest
);
  import iept_pkg::*;

  // bus state
  logic [ADDR_W-1:0] awAddr, next_awAddr;
  logic              awHeld, next_awHeld;
  logic [31:0]       wData, next_wData;
  logic [3:0]        wStrb, next_wStrb;
  logic              wHeld, next_wHeld;
  logic              next_awReady, next_wReady, next_bValid, next_arReady, next_rValid;
  logic [1:0]        next_bResp, next_rResp;
  logic [31:0]       next_rData;
  iept_wr_s          wr;

  // timer state
  logic [15:0] counter, next_counter;
  logic [15:0] reload, next_reload;
  logic        start, next_start;
  iept_mode_s  mode, next_mode;
  logic        firstEdge, next_firstEdge;
  logic        pinPrev, next_pinPrev;
  logic        subPrev, next_subPrev;
  logic [4:0]  presc, next_presc;
  logic [4:0]  subDiv, next_subDiv;
  logic        next_irq;

  // combinational helpers
  logic        tick, pinRise, pinFall, measEdge, evEdge, subRise;
  logic [15:0] timerRead;
  logic [15:0] wrTimerVal;

  // count source and edge detection
  always_comb begin
    pinRise = channelInputPin & ~pinPrev;
    pinFall = ~channelInputPin & pinPrev;
    subRise = subClock & ~subPrev;
    case (mode.sourceSelect)
      IEPT_SRC_F1:    tick = 1'b1;
      IEPT_SRC_DIV8:  tick = (presc[2:0] == IEPT_DIV8_END[2:0]);
      IEPT_SRC_DIV32: tick = (presc == IEPT_DIV32_END);
      IEPT_SRC_SUB32: tick = subRise & (subDiv == IEPT_DIV32_END);
      default:        tick = 1'b0;
    endcase
    case (mode.measureSelect)
      IEPT_MS_FALL:  measEdge = pinFall;
      IEPT_MS_RISE:  measEdge = pinRise;
      IEPT_MS_WIDTH: measEdge = pinRise | pinFall;
      default:       measEdge = 1'b0;
    endcase
    if (mode.eventFromTimer) begin
      evEdge = otherTimerOverflow;
    end else begin
      case (mode.measureSelect)
        IEPT_EV_RISE: evEdge = pinRise;
        IEPT_EV_FALL: evEdge = pinFall;
        IEPT_EV_BOTH: evEdge = pinRise | pinFall;
        default:      evEdge = 1'b0;
      endcase
    end
    timerRead = (mode.opMode == IEPT_OP_MEAS) ? reload : counter;
    wrTimerVal = reload;
    if (wr.strb[0]) begin
      wrTimerVal[7:0] = wr.data[7:0];
    end
    if (wr.strb[1]) begin
      wrTimerVal[15:8] = wr.data[15:8];
    end
  end

  // bus next state
  always_comb begin
    next_awAddr  = awAddr;
    next_awHeld  = awHeld;
    next_wData   = wData;
    next_wStrb   = wStrb;
    next_wHeld   = wHeld;
    next_bValid  = s_axi_bvalid & ~s_axi_bready;
    next_bResp   = s_axi_bresp;
    next_rValid  = s_axi_rvalid & ~s_axi_rready;
    next_rResp   = s_axi_rresp;
    next_rData   = s_axi_rdata;
    wr           = '0;
    wr.data      = wData;
    wr.strb      = wStrb;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awAddr = s_axi_awaddr;
      next_awHeld = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
      next_wHeld = 1'b1;
    end
    if (awHeld && wHeld && !s_axi_bvalid) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bValid = 1'b1;
      next_bResp  = IEPT_RESP_OK;
      case (awAddr[3:0])
        IEPT_OFS_START: wr.start = wStrb[0];
        IEPT_OFS_MODE:  wr.mode  = wStrb[0];
        IEPT_OFS_TIMER: wr.timer = |wStrb[1:0];
        default:        next_bResp = IEPT_RESP_ERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rValid = 1'b1;
      next_rResp  = IEPT_RESP_OK;
      case (s_axi_araddr[3:0])
        IEPT_OFS_START: next_rData = {31'h0, start};
        IEPT_OFS_MODE:  next_rData = {24'h0, mode};
        IEPT_OFS_TIMER: next_rData = {16'h0, timerRead};
        default: begin
          next_rData = 32'h0;
          next_rResp = IEPT_RESP_ERR;
        end
      endcase
    end
    next_awReady = ~next_awHeld & ~next_bValid;
    next_wReady  = ~next_wHeld & ~next_bValid;
    next_arReady = ~next_rValid;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awAddr        <= '0;
      awHeld        <= 1'b0;
      wData         <= 32'h0;
      wStrb         <= 4'h0;
      wHeld         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= IEPT_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= IEPT_RESP_OK;
      s_axi_rdata   <= 32'h0;
    end else begin
      awAddr        <= next_awAddr;
      awHeld        <= next_awHeld;
      wData         <= next_wData;
      wStrb         <= next_wStrb;
      wHeld         <= next_wHeld;
      s_axi_awready <= next_awReady;
      s_axi_wready  <= next_wReady;
      s_axi_bvalid  <= next_bValid;
      s_axi_bresp   <= next_bResp;
      s_axi_arready <= next_arReady;
      s_axi_rvalid  <= next_rValid;
      s_axi_rresp   <= next_rResp;
      s_axi_rdata   <= next_rData;
    end
  end

  // timer next state
  always_comb begin
    next_counter   = counter;
    next_reload    = reload;
    next_start     = start;
    next_mode      = mode;
    next_firstEdge = firstEdge;
    next_irq       = 1'b0;
    next_pinPrev   = channelInputPin;
    next_subPrev   = subClock;
    next_presc     = presc + 5'h01;
    next_subDiv    = subRise ? subDiv + 5'h01 : subDiv;
    // software writes
    if (wr.start) begin
      next_start = wr.data[0];
      if (wr.data[0] && !start) begin
        next_firstEdge = 1'b1;
      end
    end
    if (wr.mode) begin
      next_mode.sourceSelect   = wr.data[7:6];
      next_mode.eventFromTimer = wr.data[4];
      next_mode.measureSelect  = wr.data[3:2];
      next_mode.opMode         = wr.data[1:0];
      if (start) begin
        next_mode.overflowFlag = 1'b0;
      end
    end
    if (wr.timer && mode.opMode != IEPT_OP_MEAS) begin
      next_reload = wrTimerVal;
      if (!start) begin
        next_counter = wrTimerVal;
      end
    end
    // counting, only while started
    if (start) begin
      case (mode.opMode)
        IEPT_OP_TIMER, IEPT_OP_EVENT: begin
          if ((mode.opMode == IEPT_OP_TIMER) ? tick : evEdge) begin
            if (counter == IEPT_CNT_RST) begin
              next_counter = next_reload;
              next_irq     = 1'b1;
            end else begin
              next_counter = counter - 16'h0001;
            end
          end
        end
        IEPT_OP_MEAS: begin
          if (measEdge) begin
            next_reload    = counter;
            next_counter   = IEPT_CNT_RST;
            next_firstEdge = 1'b0;
            next_irq       = ~firstEdge;
          end else if (tick) begin
            next_counter = counter + 16'h0001;
            if (counter == IEPT_CNT_MAX) begin
              next_irq               = 1'b1;
              next_mode.overflowFlag = 1'b1;
            end
          end
        end
        default: next_counter = counter;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      counter    <= IEPT_CNT_RST;
      reload     <= IEPT_CNT_RST;
      start      <= 1'b0;
      mode       <= IEPT_MODE_RST;
      firstEdge  <= 1'b0;
      pinPrev    <= 1'b0;
      subPrev    <= 1'b0;
      presc      <= 5'h00;
      subDiv     <= 5'h00;
      irqRequest <= 1'b0;
    end else begin
      counter    <= next_counter;
      reload     <= next_reload;
      start      <= next_start;
      mode       <= next_mode;
      firstEdge  <= next_firstEdge;
      pinPrev    <= next_pinPrev;
      subPrev    <= next_subPrev;
      presc      <= next_presc;
      subDiv     <= next_subDiv;
      irqRequest <= next_irq;
    end
  end
endmodule // iept_timer
